// ### logic/pdw_consts.svh
/*
 Constants of the program space data window: register offsets, field
 positions, reset values and cycle counts.
 Assumes inclusion by bare name from the window design files.
*/
`ifndef PDW_CONSTS_SVH
`define PDW_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------
`define PDW_OFS_CORE_CONTROL 12'h000
`define PDW_OFS_PAGE_SELECT  12'h004
`define PDW_OFS_CPU_STATUS   12'h008
`define PDW_OFS_INT_CTRL_ONE 12'h00C

// ----------------------------------------------------------------
// Field positions, masks and reset values
// ----------------------------------------------------------------
`define PDW_CC_RESET         16'h0020
`define PDW_CC_WMASK         16'h18F7
`define PDW_CC_PRIORITY_LEVEL_MSB_BIT      3
`define PDW_CC_PSV_BIT       2
`define PDW_SR_IPL_MSB       7
`define PDW_SR_IPL_LSB       5
`define PDW_IC1_NST_BIT      15
`define PDW_PAGE_RESET       8'h00
`define PDW_IPL_LOW_RESET    3'h0
`define PDW_IPL_LOW_TOP      3'h7
`define PDW_IPL_USER_MAX     4'h7
`define PDW_EA_MSB           15

// ----------------------------------------------------------------
// Extra instruction cycles for a window access
// ----------------------------------------------------------------
`define PDW_XTRA_NONE        2'h0
`define PDW_XTRA_ONE         2'h1
`define PDW_XTRA_TWO         2'h2

`endif

// ### logic/pdw_cycle_ctl.sv
/*
 Extra-cycle accounting for window accesses: decides how many cycles the
 executing instruction is stretched and holds the core stall for them.
 Assumes the repeat qualifiers are valid in the cycle of start.
*/
`timescale 1ns/1ps
`include "pdw_consts.svh"

module pdw_cycle_ctl (
   input  wire logic           sys_clk,
   input  wire logic           rst_b,
   input  wire logic           start,
   input  pdw_pkg::pdw_op_e    op_class,
   input  wire logic           in_repeat,
   input  wire logic           rpt_first,
   input  wire logic           rpt_last,
   input  wire logic           rpt_irq_exit,
   input  wire logic           rpt_irq_reentry,
   output logic                core_stall,
   output logic [1:0]          extra_cycles
);

   logic [1:0] count_q;
   logic [1:0] count_d;
   logic       rpt_edge;

   assign rpt_edge = rpt_first | rpt_last | rpt_irq_exit | rpt_irq_reentry;

   // ----------------------------------------------------------------
   // Cost of this access
   // ----------------------------------------------------------------
   always_comb begin
      if (in_repeat) begin
         if (rpt_edge) begin
            extra_cycles = `PDW_XTRA_TWO;
         end else begin
            extra_cycles = `PDW_XTRA_NONE;
         end
      end else begin
         case (op_class)
            pdw_pkg::PDW_OP_WORD_MOVE:   extra_cycles = `PDW_XTRA_ONE;
            pdw_pkg::PDW_OP_DOUBLE_MOVE: extra_cycles = `PDW_XTRA_ONE;
            default:                     extra_cycles = `PDW_XTRA_TWO;
         endcase
      end
   end

   always_comb begin
      if (start && extra_cycles != `PDW_XTRA_NONE) begin
         count_d = extra_cycles - `PDW_XTRA_ONE;
      end else if (count_q != `PDW_XTRA_NONE) begin
         count_d = count_q - `PDW_XTRA_ONE;
      end else begin
         count_d = count_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= `PDW_XTRA_NONE;
      end else begin
         count_q <= count_d;
      end
   end

   // Stall starts in the cycle the access is taken, so the core sees it at once
   assign core_stall = (start && extra_cycles != `PDW_XTRA_NONE)
                       || (count_q != `PDW_XTRA_NONE);

endmodule

// ### logic/pdw_pkg.sv
/*
 Types shared by the program space data window files.
 Assumes nothing of its surroundings.
*/
package pdw_pkg;

   // Instruction class of the access, as decoded by the core
   typedef enum logic [1:0] {
      PDW_OP_WORD_MOVE   = 2'b00,
      PDW_OP_DOUBLE_MOVE = 2'b01,
      PDW_OP_OTHER       = 2'b10
   } pdw_op_e;

   // Window read sequencer
   typedef enum logic [1:0] {
      PDW_ST_IDLE    = 2'b00,
      PDW_ST_FETCH   = 2'b01,
      PDW_ST_CAPTURE = 2'b10
   } pdw_state_e;

endpackage

// ### logic/pdw_window.sv
/*
 Program space data window: core control, page select, priority level
 composition, the APB register slave and the redirect of upper data
 addresses onto a page of program memory.
 Assumes a synchronous program memory that returns a word one cycle
 after its read strobe, and a core that holds a data request until taken.
*/
`timescale 1ns/1ps
`include "pdw_consts.svh"

module pdw_window #(
   parameter int PAGE_W = 8,
   parameter int LOW_W  = 15
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_b,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // Core data access path
   input  wire logic                    da_req,
   input  wire logic [15:0]             da_addr,
   input  pdw_pkg::pdw_op_e             da_op_class,
   output logic                         da_ready,
   output logic      [15:0]             da_rdata,
   output logic                         da_rvalid,
   output logic                         dm_req,
   output logic      [15:0]             dm_addr,
   output logic                         core_stall,
   // Repeat loop and table operation status from the core
   input  wire logic                    in_repeat,
   input  wire logic                    rpt_first,
   input  wire logic                    rpt_last,
   input  wire logic                    rpt_irq_exit,
   input  wire logic                    rpt_irq_reentry,
   input  wire logic                    table_busy,
   // Program memory fetch port
   output logic      [PAGE_W+LOW_W-1:0] pm_addr,
   output logic                         pm_rd,
   input  wire logic [23:0]             pm_rdata,
   // Exception logic
   input  wire logic                    exc_set_level_msb,
   input  wire logic                    exc_level_load,
   input  wire logic [2:0]              exc_level_value,
   // Priority outputs
   output logic      [3:0]              cpu_priority,
   output logic                         user_irq_blocked
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [15:0]       core_control_q;
   logic [PAGE_W-1:0] window_page_select_q;
   logic [2:0]        priority_level_low_q;
   logic              nesting_disable_q;
   logic [31:0]       prdata_q;
   logic              pslverr_q;
   logic              wr_en;
   logic              rd_setup;
   logic              mapped;
   logic [31:0]       rd_mux;

   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = (paddr == `PDW_OFS_CORE_CONTROL) || (paddr == `PDW_OFS_PAGE_SELECT)
                     || (paddr == `PDW_OFS_CPU_STATUS) || (paddr == `PDW_OFS_INT_CTRL_ONE);
   assign pready   = 1'b1;

   // Core control: level msb is clear-only for software, set by exceptions
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         core_control_q <= `PDW_CC_RESET;
      end else begin
         if (wr_en && paddr == `PDW_OFS_CORE_CONTROL) begin
            core_control_q <= (pwdata[15:0] & `PDW_CC_WMASK)
                              | (core_control_q & ~`PDW_CC_WMASK);
            if (!pwdata[`PDW_CC_PRIORITY_LEVEL_MSB_BIT]) begin
               core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT] <= 1'b0;
            end
         end
         // Set wins over a clear in the same cycle
         if (exc_set_level_msb) begin
            core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         window_page_select_q <= PAGE_W'(`PDW_PAGE_RESET);
      end else if (wr_en && paddr == `PDW_OFS_PAGE_SELECT) begin
         window_page_select_q <= pwdata[PAGE_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         nesting_disable_q <= 1'b0;
      end else if (wr_en && paddr == `PDW_OFS_INT_CTRL_ONE) begin
         nesting_disable_q <= pwdata[`PDW_IC1_NST_BIT];
      end
   end

   // Exception logic may always load the level; software only without nesting disable
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         priority_level_low_q <= `PDW_IPL_LOW_RESET;
      end else if (exc_level_load) begin
         priority_level_low_q <= exc_level_value;
      end else if (wr_en && paddr == `PDW_OFS_CPU_STATUS && !nesting_disable_q) begin
         priority_level_low_q <= pwdata[`PDW_SR_IPL_MSB:`PDW_SR_IPL_LSB];
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `PDW_OFS_CORE_CONTROL: rd_mux[15:0] = core_control_q;
         `PDW_OFS_PAGE_SELECT:  rd_mux[PAGE_W-1:0] = window_page_select_q;
         `PDW_OFS_CPU_STATUS:
            rd_mux[`PDW_SR_IPL_MSB:`PDW_SR_IPL_LSB] = priority_level_low_q;
         `PDW_OFS_INT_CTRL_ONE: rd_mux[`PDW_IC1_NST_BIT] = nesting_disable_q;
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the setup phase so the access phase ends at once
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q  <= rd_setup ? rd_mux : 32'h0000_0000;
         pslverr_q <= !mapped;
      end
   end

   assign prdata  = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // ----------------------------------------------------------------
   // Priority level
   // ----------------------------------------------------------------
   assign cpu_priority = {core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT], priority_level_low_q};
   assign user_irq_blocked = core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT]
                             || (priority_level_low_q == `PDW_IPL_LOW_TOP);

   // ----------------------------------------------------------------
   // Data access redirect
   // ----------------------------------------------------------------
   pdw_pkg::pdw_state_e state_q;
   logic                win_hit;
   logic                win_take;
   logic [1:0]          extra_cycles;

   assign win_hit  = da_addr[`PDW_EA_MSB] && core_control_q[`PDW_CC_PSV_BIT];
   // Window reads wait while a table operation owns the program memory port
   assign da_ready = win_hit ? (!table_busy && state_q == pdw_pkg::PDW_ST_IDLE)
                             : 1'b1;
   assign win_take = da_req && win_hit && da_ready;
   assign dm_req   = da_req && !win_hit;
   assign dm_addr  = da_addr;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= pdw_pkg::PDW_ST_IDLE;
      end else begin
         case (state_q)
            pdw_pkg::PDW_ST_IDLE:    if (win_take) state_q <= pdw_pkg::PDW_ST_FETCH;
            pdw_pkg::PDW_ST_FETCH:   state_q <= pdw_pkg::PDW_ST_CAPTURE;
            pdw_pkg::PDW_ST_CAPTURE: state_q <= pdw_pkg::PDW_ST_IDLE;
            default:                 state_q <= pdw_pkg::PDW_ST_IDLE;
         endcase
      end
   end

   // Page on top, address low bits below: each upper data address has its own word
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pm_addr <= '0;
         pm_rd   <= 1'b0;
      end else begin
         pm_rd <= win_take;
         if (win_take) begin
            pm_addr <= {window_page_select_q, da_addr[LOW_W-1:0]};
         end
      end
   end

   // The upper program byte is dropped; it is never data
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         da_rdata  <= 16'h0000;
         da_rvalid <= 1'b0;
      end else begin
         da_rvalid <= (state_q == pdw_pkg::PDW_ST_CAPTURE);
         if (state_q == pdw_pkg::PDW_ST_CAPTURE) begin
            da_rdata <= pm_rdata[15:0];
         end
      end
   end

   pdw_cycle_ctl u_cycle_ctl (
      .sys_clk         (sys_clk),
      .rst_b           (rst_b),
      .start           (win_take),
      .op_class        (da_op_class),
      .in_repeat       (in_repeat),
      .rpt_first       (rpt_first),
      .rpt_last        (rpt_last),
      .rpt_irq_exit    (rpt_irq_exit),
      .rpt_irq_reentry (rpt_irq_reentry),
      .core_stall      (core_stall),
      .extra_cycles    (extra_cycles)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_REDIRECT_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      win_take |=> pm_rd
                   && pm_addr == {$past(window_page_select_q), $past(da_addr[LOW_W-1:0])})
      else $error("window address not page and low address bits");

   AST_NO_REDIRECT_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (da_req && !da_addr[`PDW_EA_MSB]) |-> dm_req && !win_take)
      else $error("lower data address was redirected");

   AST_PLAIN_PASS: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (da_req && !win_hit) |-> da_ready && dm_req && dm_addr == da_addr)
      else $error("plain data access not passed through");

   AST_ENABLE_GATES: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (da_req && !core_control_q[`PDW_CC_PSV_BIT]) |-> !win_take ##1 !pm_rd)
      else $error("window used while disabled");

   AST_ENABLE_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wr_en && paddr == `PDW_OFS_CORE_CONTROL)
      |=> core_control_q[`PDW_CC_PSV_BIT] == $past(pwdata[`PDW_CC_PSV_BIT]))
      else $error("window enable not written");

   AST_PAGE_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wr_en && paddr == `PDW_OFS_PAGE_SELECT)
      |=> window_page_select_q == $past(pwdata[PAGE_W-1:0]))
      else $error("page select not written");

   AST_LOW_HALF: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pm_rd |=> ##1 da_rvalid && da_rdata == $past(pm_rdata[15:0]))
      else $error("window data not the low half of the word");

   AST_RVALID_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      da_rvalid |=> !da_rvalid)
      else $error("read data valid longer than one cycle");

   AST_SEQ_REFUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (da_req && win_hit && state_q != pdw_pkg::PDW_ST_IDLE) |-> !da_ready)
      else $error("window request taken while sequencer busy");

   AST_READ_STRETCH: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (win_take && !in_repeat) |-> core_stall)
      else $error("window read not stretched");

   AST_TABLE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
      table_busy |-> !win_take ##1 !pm_rd)
      else $error("window access during table operation");

   AST_MOVE_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (win_take && !in_repeat && da_op_class != pdw_pkg::PDW_OP_OTHER)
      |-> core_stall ##1 !core_stall)
      else $error("move access not stretched by one cycle");

   AST_MOVE_COST: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (win_take && !in_repeat && da_op_class != pdw_pkg::PDW_OP_OTHER)
      |-> extra_cycles == `PDW_XTRA_ONE)
      else $error("move access cost not one cycle");

   AST_OTHER_TWO: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (win_take && (in_repeat ? (rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reentry)
                              : da_op_class == pdw_pkg::PDW_OP_OTHER))
      |-> core_stall [*2] ##1 !core_stall)
      else $error("access not stretched by two cycles");

   AST_REPEAT_SINGLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (win_take && in_repeat && !(rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reentry))
      |-> !core_stall)
      else $error("middle repeat iteration stretched");

   AST_PRIORITY: assert property (@(posedge sys_clk) disable iff (!rst_b)
      user_irq_blocked == (cpu_priority > `PDW_IPL_USER_MAX
                           || cpu_priority[2:0] == `PDW_IPL_LOW_TOP))
      else $error("user interrupt block does not follow priority");

   AST_SR_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (nesting_disable_q && !exc_level_load) |=> $stable(priority_level_low_q))
      else $error("status priority bits changed under nesting disable");

   AST_SW_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wr_en && paddr == `PDW_OFS_CPU_STATUS && !nesting_disable_q && !exc_level_load)
      |=> priority_level_low_q == $past(pwdata[`PDW_SR_IPL_MSB:`PDW_SR_IPL_LSB]))
      else $error("status priority bits not written");

   AST_MSB_CLEAR_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT] && !exc_set_level_msb)
      |=> !core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT])
      else $error("level msb set without exception");

   AST_MSB_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
      exc_set_level_msb |=> core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT])
      else $error("level msb not set by exception");

   COV_WINDOW_READ: cover property (@(posedge sys_clk) disable iff (!rst_b)
      win_take ##2 da_rvalid);
   COV_TABLE_WAIT: cover property (@(posedge sys_clk) disable iff (!rst_b)
      (da_req && win_hit && table_busy) ##1 win_take);
   COV_REPEAT_FAST: cover property (@(posedge sys_clk) disable iff (!rst_b)
      win_take && in_repeat && !rpt_first && !rpt_last);
   COV_BLOCKED: cover property (@(posedge sys_clk) disable iff (!rst_b)
      user_irq_blocked && !core_control_q[`PDW_CC_PRIORITY_LEVEL_MSB_BIT]);

endmodule

// ### tb/pdw_pmem_model.sv
/*
 Program memory model for the data window bench: answers a read strobe
 with a 24-bit word in the following cycle.
 Assumes pm_rd is a one-cycle pulse with pm_addr valid beside it.
*/
`timescale 1ns/1ps

module pdw_pmem_model (
   input  wire logic        sys_clk,
   input  wire logic [22:0] pm_addr,
   input  wire logic        pm_rd,
   output logic      [23:0] pm_rdata
);
   // ----------------------------------------------------------------
   // Stored word pattern
   // ----------------------------------------------------------------
   // Upper byte all ones or all zeros, so a stray fetch acts as a no-op
   function automatic logic [23:0] pdw_word(input logic [22:0] a);
      return {{8{a[0]}}, a[15:0] ^ {a[22:15], 8'hC3}};
   endfunction

   initial pm_rdata = 24'h5A5A5A;

   // Outside the answer cycle the bus toggles, so a sample one cycle late reads the inverted word
   always @(posedge sys_clk) begin
      if (pm_rd) begin
         pm_rdata <= pdw_word(pm_addr);
      end else begin
         pm_rdata <= ~pm_rdata;
      end
   end
endmodule

// ### tb/pdw_window_tb.sv
/*
 Self-checking bench of the program space data window.
 Assumes the window top, the package and the program memory model.
*/
`timescale 1ns/1ps

module pdw_window_tb;
   logic             sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, seed, rd;
   logic             da_req, da_ready, da_rvalid, dm_req, core_stall, err;
   logic [15:0]      da_addr, da_rdata, dm_addr, a;
   pdw_pkg::pdw_op_e da_op_class;
   logic             in_repeat, rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry;
   logic             table_busy, pm_rd, exc_set_level_msb, exc_level_load, user_irq_blocked;
   logic [22:0]      pm_addr;
   logic [23:0]      pm_rdata;
   logic [2:0]       exc_level_value;
   logic [3:0]       cpu_priority;
   logic [7:0]       pg;
   logic [4:0]       rtab [6];
   int               n_mismatch, checks_done, cyc;

   pdw_window #(.PAGE_W(8), .LOW_W(15)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .da_req(da_req), .da_addr(da_addr), .da_op_class(da_op_class), .da_ready(da_ready),
      .da_rdata(da_rdata), .da_rvalid(da_rvalid), .dm_req(dm_req), .dm_addr(dm_addr),
      .core_stall(core_stall), .in_repeat(in_repeat), .rpt_first(rpt_first),
      .rpt_last(rpt_last), .rpt_irq_exit(rpt_irq_exit), .rpt_irq_reentry(rpt_irq_reentry),
      .table_busy(table_busy), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
      .exc_set_level_msb(exc_set_level_msb), .exc_level_load(exc_level_load),
      .exc_level_value(exc_level_value), .cpu_priority(cpu_priority),
      .user_irq_blocked(user_irq_blocked));

   pdw_pmem_model mem (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
      .pm_rdata(pm_rdata));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic int exp_stall(input int op, input logic [4:0] rp);
      if (rp[4]) return (rp[3:0] != 4'h0) ? 2 : 0;
      return (op == 2) ? 2 : 1;
   endfunction

   function automatic logic [15:0] exp_word(input logic [22:0] x);
      return x[15:0] ^ {x[22:15], 8'hC3};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Request held until pready is seen high at a rising edge; data taken there
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Let a write settle before outputs are looked at
      @(negedge sys_clk);
   endtask

   task automatic win(input logic [15:0] ea, input int op, input logic [4:0] rp);
      logic [22:0] pa;
      int          st;
      pa = {pg, ea[14:0]};
      @(posedge sys_clk);
      table_busy  <= 1'b0;
      da_req      <= 1'b1;
      da_addr     <= ea;
      da_op_class <= pdw_pkg::pdw_op_e'(op[1:0]);
      {in_repeat, rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} <= rp;
      do @(negedge sys_clk); while (da_ready !== 1'b1);
      chk("window dm_req", 32'h0, 32'(dm_req));
      st = int'(core_stall === 1'b1);
      @(posedge sys_clk);
      da_req <= 1'b0;
      {in_repeat, rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} <= 5'h00;
      @(negedge sys_clk);
      st += int'(core_stall === 1'b1);
      chk("pm_rd", 32'h1, 32'(pm_rd));
      chk("pm_addr", 32'(pa), 32'(pm_addr));
      @(negedge sys_clk);
      st += int'(core_stall === 1'b1);
      @(negedge sys_clk);
      st += int'(core_stall === 1'b1);
      chk("da_rvalid", 32'h1, 32'(da_rvalid));
      chk("da_rdata", 32'(exp_word(pa)), 32'(da_rdata));
      chk("stall cycles", 32'(exp_stall(op, rp)), 32'(st));
   endtask

   // ----------------------------------------------------------------
   // Clock and timeout
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      cyc = 0;
      forever begin
         @(posedge sys_clk);
         cyc++;
         if (cyc == 5000) begin
            n_mismatch++;
            $display("Error timeout expected end seen hang");
            final_report();
         end
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_b, psel, penable, pwrite, da_req, table_busy} = 6'h00;
      {in_repeat, rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} = 5'h00;
      {exc_set_level_msb, exc_level_load, exc_level_value} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      da_addr = 16'h0000;
      da_op_class = pdw_pkg::PDW_OP_WORD_MOVE;
      rtab = '{5'h00, 5'h18, 5'h14, 5'h12, 5'h11, 5'h10};
      seed = 32'h000063CA;
      pg = 8'h00;
      n_mismatch = 0;
      checks_done = 0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("core_control reset", 32'h0020, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("page reset", 32'h0, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      apb(1'b1, 12'h000, 32'hFFFF);
      apb(1'b0, 12'h000, 32'h0);
      chk("core_control mask", 32'h18F7, rd);
      apb(1'b1, 12'h008, 32'hE0);
      chk("level seven", 32'h7, 32'(cpu_priority));
      chk("blocked at seven", 32'h1, 32'(user_irq_blocked));
      apb(1'b1, 12'h008, 32'h60);
      chk("blocked at three", 32'h0, 32'(user_irq_blocked));
      @(posedge sys_clk);
      exc_set_level_msb <= 1'b1;
      @(posedge sys_clk);
      exc_set_level_msb <= 1'b0;
      @(negedge sys_clk);
      chk("level with msb", 32'hB, 32'(cpu_priority));
      chk("blocked by msb", 32'h1, 32'(user_irq_blocked));
      apb(1'b1, 12'h000, 32'h4);
      chk("msb cleared", 32'h3, 32'(cpu_priority));
      apb(1'b1, 12'h00C, 32'h8000);
      apb(1'b1, 12'h008, 32'hA0);
      apb(1'b0, 12'h008, 32'h0);
      chk("status locked", 32'h60, rd);
      @(posedge sys_clk);
      exc_level_load  <= 1'b1;
      exc_level_value <= 3'h2;
      @(posedge sys_clk);
      exc_level_load <= 1'b0;
      @(negedge sys_clk);
      chk("level loaded", 32'h2, 32'(cpu_priority));
      apb(1'b1, 12'h00C, 32'h0);
      // Every op class against every repeat position, pages at both ends
      for (int i = 0; i < 18; i++) begin
         seed = xs(seed);
         pg = (i == 0) ? 8'h00 : (i == 17) ? 8'hFF : seed[23:16];
         a = (i == 0) ? 16'h8000 : (i == 17) ? 16'hFFFF : {1'b1, seed[14:0]};
         apb(1'b1, 12'h004, {24'h0, pg});
         win(a, i % 3, rtab[i / 3]);
      end
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         a = {k[0], seed[14:0]};
         if (k == 1) apb(1'b1, 12'h000, 32'h0);
         @(posedge sys_clk);
         da_req  <= 1'b1;
         da_addr <= a;
         @(negedge sys_clk);
         chk("plain dm_req", 32'h1, 32'(dm_req));
         chk("plain dm_addr", 32'(a), 32'(dm_addr));
         chk("plain stall", 32'h0, 32'(core_stall));
         @(posedge sys_clk);
         da_req <= 1'b0;
      end
      apb(1'b1, 12'h000, 32'h4);
      @(posedge sys_clk);
      table_busy  <= 1'b1;
      da_req      <= 1'b1;
      da_addr     <= 16'h9000;
      da_op_class <= pdw_pkg::PDW_OP_OTHER;
      repeat (4) begin
         @(negedge sys_clk);
         chk("busy ready", 32'h0, 32'(da_ready));
         chk("busy fetch", 32'h0, 32'(pm_rd));
      end
      win(16'h9000, 2, 5'h00);
      final_report();
   end
endmodule
